// ### hdl/i2c_master_defines.vh
// Purpose: Constants for the two-unit I2C master command engine.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus.
// Notes: Register data sits in bits 7:0 of each word.
`ifndef I2C_MASTER_DEFINES_VH
`define I2C_MASTER_DEFINES_VH

// Register byte addresses
`define ADDR_UNIT_SELECT 8'h00
`define ADDR_MASTER_CONTROL 8'h04
`define ADDR_MASTER_STATUS 8'h08
`define ADDR_TARGET_ADDRESS 8'h0C
`define ADDR_TRANSMIT_DATA 8'h10
`define ADDR_RECEIVE_DATA 8'h14

// bus_unit_select fields
`define SEL_UNIT_BIT 0
`define SEL_WAKE_ZERO_BIT 6
`define SEL_WAKE_ONE_BIT 7

// master_control fields
`define CTL_ENABLE_BIT 7
`define CTL_PIN_PAIR_BIT 6
`define CTL_RATE_HI 5
`define CTL_RATE_LO 4
`define CTL_CMD_HI 3
`define CTL_CMD_LO 2
`define CTL_GO_BIT 1
`define CTL_IRQ_EN_BIT 0

// master_status fields
`define STA_SCL_BIT 7
`define STA_SDA_BIT 6
`define STA_RESULT_HI 2
`define STA_RESULT_LO 1
`define STA_DONE_BIT 0

// Reset values
`define RESET_BYTE 8'h00

// Command codes
`define CMD_START 2'h0
`define CMD_BYTE 2'h1
`define CMD_LAST 2'h2
`define CMD_STOP 2'h3

// Result codes
`define RES_OK 2'h0
`define RES_NACK 2'h1
`define RES_ARB_LOST 2'h2

// SCL period is 128 << rate; one bit takes four quarter ticks
`define QUARTER_DIV_BASE 10'h020

`endif

// ### hdl/i2c_bit_engine.v
// Purpose: Bit-level I2C master engine for one unit.
// Assumes: Pin levels arrive synchronous to clk_i.
// Notes: Each bus bit spans four quarter ticks from a clock divider.
`timescale 1ns/1ns
`include "i2c_master_defines.vh"

module i2c_bit_engine (
  input wire clk_i,
  input wire rst_i,
  input wire enable_i,
  input wire [1:0] rate_i,
  input wire take_i,
  input wire [1:0] cmd_i,
  input wire [7:0] addr_word_i,
  input wire [7:0] tx_byte_i,
  input wire scl_i,
  input wire sda_i,
  output wire idle_o,
  output reg scl_low_o,
  output reg sda_low_o,
  output reg done_o,
  output reg [1:0] result_o,
  output reg [7:0] rx_byte_o
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_START = 4'h2;
  localparam [3:0] ST_XFER = 4'h4;
  localparam [3:0] ST_STOP = 4'h8;

  reg [3:0] state;
  reg [1:0] quarter;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg rx_mode;
  reg no_ack;
  reg [9:0] div;
  wire tick;
  wire [9:0] reload;
  wire out_low;
  wire hold;

  assign idle_o = (state == ST_IDLE);
  // Quarter-period divider: 32, 64, 128 or 256 clocks
  assign reload = (`QUARTER_DIV_BASE << rate_i) - 10'h001; // R05
  assign tick = (div == 10'h000);
  // Stretching: wait in quarter 2 until SCL is seen high
  assign hold = (quarter == 2'h2) && !scl_i;
  // Data bits from the shifter, ack bit driven only when receiving
  assign out_low = (bit_cnt == 4'h8) ? (rx_mode && !no_ack) : (!rx_mode && !shift[7]); // R08 R10

  // Divider runs freely, also when idle, restarts with each command
  always @(posedge clk_i) begin
    if (rst_i || take_i || div == 10'h000) begin
      div <= reload;
    end else begin
      div <= div - 10'h001;
    end
  end

  // Command sequencer
  always @(posedge clk_i) begin
    if (rst_i || !enable_i) begin
      state <= ST_IDLE; // R02
      quarter <= 2'h0;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      rx_mode <= 1'b0;
      no_ack <= 1'b0;
      scl_low_o <= 1'b0;
      sda_low_o <= 1'b0;
      done_o <= 1'b0;
      result_o <= `RES_OK;
      rx_byte_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      if (state != ST_IDLE && tick && !hold) begin
        quarter <= quarter + 2'h1;
      end
      case (state)
        ST_IDLE: begin
          if (take_i) begin
            quarter <= 2'h0;
            bit_cnt <= 4'h0;
            no_ack <= (cmd_i == `CMD_LAST); // R10
            if (cmd_i == `CMD_START) begin
              state <= ST_START; // R07
              shift <= addr_word_i;
              rx_mode <= 1'b0;
            end else if (cmd_i == `CMD_STOP) begin
              state <= ST_STOP; // R11
            end else begin
              state <= ST_XFER;
              rx_mode <= addr_word_i[0]; // R17
              shift <= addr_word_i[0] ? 8'hFF : tx_byte_i; // R08
            end
          end
        end
        ST_START: begin
          // Works from idle and as a repeated start with SCL low
          if (tick && !hold) begin
            case (quarter)
              2'h0: sda_low_o <= 1'b0; // R19
              2'h1: scl_low_o <= 1'b0;
              2'h2: sda_low_o <= 1'b1;
              default: begin
                scl_low_o <= 1'b1;
                state <= ST_XFER;
              end
            endcase
          end
        end
        ST_XFER: begin
          if (tick && !hold) begin
            case (quarter)
              2'h0: sda_low_o <= out_low;
              2'h1: scl_low_o <= 1'b0;
              2'h2: scl_low_o <= 1'b0;
              default: begin
                if (bit_cnt != 4'h8 && !rx_mode && shift[7] && !sda_i) begin
                  scl_low_o <= 1'b0; // R22
                  sda_low_o <= 1'b0;
                  result_o <= `RES_ARB_LOST; // R09
                  done_o <= 1'b1;
                  state <= ST_IDLE;
                end else if (bit_cnt == 4'h8) begin
                  scl_low_o <= 1'b1;
                  sda_low_o <= 1'b0;
                  result_o <= (!rx_mode && sda_i) ? `RES_NACK : `RES_OK; // R09
                  if (rx_mode) begin
                    rx_byte_o <= shift; // R21
                  end
                  done_o <= 1'b1; // R13
                  state <= ST_IDLE;
                end else begin
                  scl_low_o <= 1'b1;
                  shift <= {shift[6:0], sda_i};
                  bit_cnt <= bit_cnt + 4'h1;
                end
              end
            endcase
          end
        end
        ST_STOP: begin
          if (tick && !hold) begin
            case (quarter)
              2'h0: begin
                scl_low_o <= 1'b1;
                sda_low_o <= 1'b1;
              end
              2'h1: scl_low_o <= 1'b0;
              2'h2: scl_low_o <= 1'b0;
              default: begin
                sda_low_o <= 1'b0; // R11
                result_o <= `RES_OK;
                done_o <= 1'b1;
                state <= ST_IDLE;
              end
            endcase
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule

// ### hdl/i2c_master_command_engine.v
// Purpose: Two command-driven I2C master units behind one Wishbone window.
// Assumes: Open-drain pins with external pull-ups; pins sampled on clk_i.
// Notes: Registers sit in bits 7:0 of each word; byte lane 0 writes them.
//
// Behaviour
// [R01] Unit select bit picks unit register set
// [R02] Disabled master releases both SCL and SDA
// [R03] Pin pair select picks alternative or primary pins
// [R04] Unit zero pins 0/1 or 2/3, one 4/5
// [R05] Rate code divides clock by 128..1024
// [R06] Software orders start, bytes, then stop
// [R07] Command 00 sends start and address word
// [R08] Command 01 moves byte, acks when receiving
// [R09] Result code reports ok, nack or arbitration lost
// [R10] Command 10 leaves ack undriven when receiving
// [R11] Command 11 sends a stop condition
// [R12] Go bit clears itself when command accepted
// [R13] Finished command sets done flag and result
// [R14] Done flag clears only by writing one
// [R15] Interrupt follows done flag gated by enable
// [R16] Status shows live SCL and SDA levels
// [R17] Address bits 7:1, bit 0 selects direction
// [R18] Software loads transmit byte before byte command
// [R19] Works with other masters and repeated starts
// [R20] Wake enable raises wake on low line
// [R21] Received byte lands in receive register
// [R22] Arbitration loss releases bus, reports code 10
`timescale 1ns/1ns
`include "i2c_master_defines.vh"

module i2c_master_command_engine (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire [5:0] port_pin_i,
  output wire [5:0] port_pin_o,
  output wire [5:0] port_pin_oe_n_o,
  output wire [1:0] irq_o,
  output reg [1:0] wake_o
);

  ////////////////////////////////////////////////////////////////////////
  // Bus slave front end

  wire access;
  wire wr_en;
  reg unit_sel;
  reg wake_en_zero;
  reg wake_en_one;

  // One request is served per ack; ack drops the cycle after
  assign access = cyc_i && stb_i && !ack_o;
  assign wr_en = access && we_i && sel_i[0];

  // Single cycle acknowledge for every address, mapped or not
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= access;
    end
  end

  // Unit select and wake enables
  always @(posedge clk_i) begin
    if (rst_i) begin
      unit_sel <= 1'b0;
      wake_en_zero <= 1'b0;
      wake_en_one <= 1'b0;
    end else if (wr_en && adr_i == `ADDR_UNIT_SELECT) begin
      unit_sel <= dat_i[`SEL_UNIT_BIT]; // R01
      wake_en_zero <= dat_i[`SEL_WAKE_ZERO_BIT];
      wake_en_one <= dat_i[`SEL_WAKE_ONE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-unit registers and engines

  wire [1:0] master_en;
  wire [1:0] pin_pair;
  wire [3:0] rate;
  wire [3:0] cmd;
  wire [1:0] go;
  wire [1:0] irq_en;
  wire [1:0] done_flag;
  wire [15:0] addr_word;
  wire [15:0] tx_byte;
  wire [15:0] rx_byte;
  wire [3:0] result;
  wire [1:0] eng_idle;
  wire [1:0] eng_done;
  wire [1:0] scl_low;
  wire [1:0] sda_low;
  wire [1:0] scl_in;
  wire [1:0] sda_in;

  genvar u;
  generate
    for (u = 0; u < 2; u = u + 1) begin : unit_g
      reg en_r;
      reg pair_r;
      reg [1:0] rate_r;
      reg [1:0] cmd_r;
      reg go_r;
      reg irq_en_r;
      reg flag_r;
      reg [7:0] addr_r;
      reg [7:0] tx_r;
      wire sel_me;
      wire wr_ctl;
      wire wr_sta;
      wire take;

      assign sel_me = (unit_sel == u); // R01
      assign wr_ctl = wr_en && sel_me && adr_i == `ADDR_MASTER_CONTROL;
      assign wr_sta = wr_en && sel_me && adr_i == `ADDR_MASTER_STATUS;
      // Command accepted only by an enabled, idle engine
      assign take = go_r && en_r && eng_idle[u]; // R12

      // Control register; go is cleared by the engine on acceptance
      always @(posedge clk_i) begin
        if (rst_i) begin
          en_r <= 1'b0;
          pair_r <= 1'b0;
          rate_r <= 2'h0;
          cmd_r <= 2'h0;
          go_r <= 1'b0;
          irq_en_r <= 1'b0;
        end else begin
          if (wr_ctl) begin
            en_r <= dat_i[`CTL_ENABLE_BIT]; // R02
            pair_r <= dat_i[`CTL_PIN_PAIR_BIT]; // R03
            rate_r <= dat_i[`CTL_RATE_HI:`CTL_RATE_LO]; // R05
            cmd_r <= dat_i[`CTL_CMD_HI:`CTL_CMD_LO];
            irq_en_r <= dat_i[`CTL_IRQ_EN_BIT];
          end
          if (take) begin
            go_r <= 1'b0; // R12
          end else if (wr_ctl) begin
            go_r <= dat_i[`CTL_GO_BIT];
          end
        end
      end

      // Done flag: a completion in the clearing cycle wins
      always @(posedge clk_i) begin
        if (rst_i) begin
          flag_r <= 1'b0;
        end else begin
          flag_r <= eng_done[u] | (flag_r & !(wr_sta && dat_i[`STA_DONE_BIT])); // R13 R14
        end
      end

      // Address word and transmit byte
      always @(posedge clk_i) begin
        if (rst_i) begin
          addr_r <= `RESET_BYTE;
          tx_r <= `RESET_BYTE;
        end else begin
          if (wr_en && sel_me && adr_i == `ADDR_TARGET_ADDRESS) begin
            addr_r <= dat_i[7:0]; // R17
          end
          if (wr_en && sel_me && adr_i == `ADDR_TRANSMIT_DATA) begin
            tx_r <= dat_i[7:0]; // R18
          end
        end
      end

      assign master_en[u] = en_r;
      assign pin_pair[u] = pair_r;
      assign rate[2*u+1:2*u] = rate_r;
      assign cmd[2*u+1:2*u] = cmd_r;
      assign go[u] = go_r;
      assign irq_en[u] = irq_en_r;
      assign done_flag[u] = flag_r;
      assign addr_word[8*u+7:8*u] = addr_r;
      assign tx_byte[8*u+7:8*u] = tx_r;
      // Interrupt request per unit
      assign irq_o[u] = flag_r & irq_en_r; // R15

      i2c_bit_engine engine (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(en_r),
        .rate_i(rate_r),
        .take_i(take),
        .cmd_i(cmd_r),
        .addr_word_i(addr_r),
        .tx_byte_i(tx_r),
        .scl_i(scl_in[u]),
        .sda_i(sda_in[u]),
        .idle_o(eng_idle[u]),
        .scl_low_o(scl_low[u]),
        .sda_low_o(sda_low[u]),
        .done_o(eng_done[u]),
        .result_o(result[2*u+1:2*u]),
        .rx_byte_o(rx_byte[8*u+7:8*u])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Pin routing

  wire zero_alt;
  wire [1:0] pull_scl;
  wire [1:0] pull_sda;

  // Unit zero picks pins 0/1 or 2/3; unit one always uses 4/5
  assign zero_alt = pin_pair[0]; // R03
  assign scl_in[0] = zero_alt ? port_pin_i[2] : port_pin_i[0]; // R04
  assign sda_in[0] = zero_alt ? port_pin_i[3] : port_pin_i[1];
  assign scl_in[1] = port_pin_i[4]; // R04
  assign sda_in[1] = port_pin_i[5];

  // A disabled master pulls nothing
  assign pull_scl = scl_low & master_en; // R02
  assign pull_sda = sda_low & master_en; // R02

  // Open drain: level is always low, enable active low while pulling
  assign port_pin_o = 6'h00;
  assign port_pin_oe_n_o[0] = !(pull_scl[0] && !zero_alt);
  assign port_pin_oe_n_o[1] = !(pull_sda[0] && !zero_alt);
  assign port_pin_oe_n_o[2] = !(pull_scl[0] && zero_alt);
  assign port_pin_oe_n_o[3] = !(pull_sda[0] && zero_alt);
  assign port_pin_oe_n_o[4] = !pull_scl[1];
  assign port_pin_oe_n_o[5] = !pull_sda[1];

  ////////////////////////////////////////////////////////////////////////
  // Wake requests

  // A low line on a unit with its wake enable set requests wake from stop
  always @(posedge clk_i) begin
    if (rst_i) begin
      wake_o <= 2'h0;
    end else begin
      wake_o[0] <= wake_en_zero && (!scl_in[0] || !sda_in[0]); // R20
      wake_o[1] <= wake_en_one && (!scl_in[1] || !sda_in[1]); // R20
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data

  wire [7:0] ctl_view;
  wire [7:0] sta_view;
  wire [7:0] addr_view;
  wire [7:0] tx_view;
  wire [7:0] rx_view;
  reg [7:0] next_rd;

  // Views of the selected unit
  assign ctl_view = {master_en[unit_sel], pin_pair[unit_sel],
                     rate[2*unit_sel+1], rate[2*unit_sel],
                     cmd[2*unit_sel+1], cmd[2*unit_sel],
                     go[unit_sel], irq_en[unit_sel]};
  assign sta_view = {scl_in[unit_sel], sda_in[unit_sel], 3'h0,
                     result[2*unit_sel+1], result[2*unit_sel],
                     done_flag[unit_sel]}; // R16 R09
  assign addr_view = unit_sel ? addr_word[15:8] : addr_word[7:0];
  assign tx_view = unit_sel ? tx_byte[15:8] : tx_byte[7:0];
  assign rx_view = unit_sel ? rx_byte[15:8] : rx_byte[7:0]; // R21

  // Address decode; unmapped addresses read zero
  always @* begin
    next_rd = 8'h00;
    if (adr_i == `ADDR_UNIT_SELECT) begin
      next_rd = {wake_en_one, wake_en_zero, 5'h00, unit_sel};
    end else if (adr_i == `ADDR_MASTER_CONTROL) begin
      next_rd = ctl_view;
    end else if (adr_i == `ADDR_MASTER_STATUS) begin
      next_rd = sta_view;
    end else if (adr_i == `ADDR_TARGET_ADDRESS) begin
      next_rd = addr_view;
    end else if (adr_i == `ADDR_TRANSMIT_DATA) begin
      next_rd = tx_view;
    end else if (adr_i == `ADDR_RECEIVE_DATA) begin
      next_rd = rx_view;
    end
  end

  // Read data registered with the acknowledge
  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (access && !we_i) begin
      dat_o <= {24'h000000, next_rd};
    end
  end

endmodule

// ### test/i2c_engine_monitor.sv
// Purpose: Port checker for the I2C command engine.
// Assumes: Registered ack one cycle after a request.
// Notes: Bound into the top module.
`timescale 1ns/1ns
module i2c_engine_monitor (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire [5:0] port_pin_i,
  input wire [5:0] port_pin_o,
  input wire [5:0] port_pin_oe_n_o,
  input wire [1:0] irq_o,
  input wire [1:0] wake_o
);
  reg unit;
  wire take;
  assign take = cyc_i && stb_i && !ack_o;
  // Follow the selected register set
  always @(posedge clk_i) begin
    if (rst_i) begin
      unit <= 1'b0;
    end else if (take && we_i && sel_i[0] && adr_i == 8'h00) begin
      unit <= dat_i[0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  property p_ack; take |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_hole; take && !we_i && adr_i == 8'h20 |=> dat_o == 32'h00000000; endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  property p_upper; ack_o |-> dat_o[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_drain; port_pin_o == 6'h00; endproperty
  a_drain: assert property (p_drain) else $error("pin driven high");
  property p_release; $fell(rst_i) |-> port_pin_oe_n_o == 6'h3F && !ack_o; endproperty
  a_release: assert property (p_release) else $error("lines held after reset");
  property p_off;
    take && we_i && sel_i[0] && adr_i == 8'h04 && !dat_i[7] && !unit
      |=> ##1 port_pin_oe_n_o[3:0] == 4'hF;
  endproperty
  a_off: assert property (p_off) else $error("disabled unit drives");
  property p_scl_low; $fell(port_pin_oe_n_o[0]) |=> !port_pin_oe_n_o[0] [*8]; endproperty
  a_scl_low: assert property (p_scl_low) else $error("clock low too short");
  property p_irq_clr; $fell(irq_o[0]) |-> $past(take && we_i); endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq dropped alone");
  property p_wake; wake_o[1] |-> $past(!(port_pin_i[4] && port_pin_i[5])); endproperty
  a_wake: assert property (p_wake) else $error("wake with lines high");
endmodule
bind i2c_master_command_engine i2c_engine_monitor u_i2c_engine_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .port_pin_i(port_pin_i), .port_pin_o(port_pin_o),
  .port_pin_oe_n_o(port_pin_oe_n_o), .irq_o(irq_o), .wake_o(wake_o));

// ### test/i2c_slave_model.sv
// Purpose: Behavioural I2C slave on one line pair.
// Assumes: Lines resolved with pull-ups outside.
// Notes: pull_o high pulls the data line low.
`timescale 1ns/1ns
module i2c_slave_model #(
  parameter [6:0] ID = 7'h50,
  parameter [7:0] RDATA = 8'hA5
) (
  input wire scl_i,
  input wire sda_i,
  output reg pull_o,
  output reg [7:0] got_o,
  output reg ack_o
);
  reg [7:0] sh;
  reg act;
  reg rd;
  reg adr;
  integer bc;
  initial begin
    pull_o = 1'b0;
    act = 1'b0;
    got_o = 8'h00;
    ack_o = 1'b1;
  end
  // Start or repeated start opens a frame
  always @(negedge sda_i) begin
    if (scl_i === 1'b1) begin
      act = 1'b1;
      adr = 1'b1;
      rd = 1'b0;
      bc = 0;
      pull_o = 1'b0;
    end
  end
  // Stop closes the frame
  always @(posedge sda_i) begin
    if (scl_i === 1'b1) begin
      act = 1'b0;
      pull_o = 1'b0;
    end
  end
  // Sample bits and the master's acknowledge
  always @(posedge scl_i) begin
    if (act) begin
      bc = bc + 1;
      if (bc <= 8) sh = {sh[6:0], sda_i};
      if (bc == 9) ack_o = sda_i;
      if (bc == 9 && rd && !adr && sda_i) act = 1'b0;
    end
  end
  // Change the data line only while the clock is low
  always @(negedge scl_i) begin
    if (act) begin
      if (bc == 8) begin
        if (adr) begin
          rd = sh[0];
          act = (sh[7:1] == ID);
          pull_o = act;
        end else begin
          if (!rd) got_o = sh;
          pull_o = !rd;
        end
      end else if (bc == 9) begin
        bc = 0;
        adr = 1'b0;
        pull_o = rd & ~RDATA[7];
      end else if (rd && !adr && bc > 0) begin
        pull_o = ~RDATA[7 - bc];
      end
    end
  end
endmodule

// ### test/i2c_master_command_engine_tb_top.sv
// Purpose: Self-checking bench for the I2C command engine.
// Assumes: Ack one cycle after a request.
// Notes: Slave sits on the primary pair of unit zero.
`timescale 1ns/1ns
module i2c_master_command_engine_tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg cyc = 1'b0;
  reg stb = 1'b0;
  reg we = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [31:0] dat_w = 32'h00000000;
  reg drag = 1'b0;
  reg chk = 1'b0;
  reg touched = 1'b0;
  reg scl_d;
  reg [31:0] seed = 32'h0000003A;
  reg [31:0] eq[$];
  reg [31:0] mq[$];
  reg [7:0] tx;
  reg [31:0] rv;
  reg [1:0] rate;
  integer err_total = 0;
  integer comparisons = 0;
  integer cyc_n = 0;
  integer last_rise = 0;
  integer period = 0;
  wire [31:0] dat_r;
  wire ack, pull, sack;
  wire [5:0] oe_n, pins;
  wire [1:0] irq, wake;
  wire [7:0] got;
  // Open-drain lines with pull-ups
  assign pins = {oe_n[5], oe_n[4] & ~drag, oe_n[3:2], oe_n[1] & ~pull, oe_n[0]};
  i2c_master_command_engine u_i2c_master_command_engine (.clk_i(clk), .rst_i(rst),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(dat_w),
    .dat_o(dat_r), .ack_o(ack), .port_pin_i(pins), .port_pin_o(), .port_pin_oe_n_o(oe_n),
    .irq_o(irq), .wake_o(wake));
  i2c_slave_model u_i2c_slave_model (.scl_i(pins[0]), .sda_i(pins[1]), .pull_o(pull),
    .got_o(got), .ack_o(sack));
  initial begin
    forever #50 clk = ~clk;
  end
  // Clock period and primary-pair activity
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    scl_d <= pins[0];
    if (pins[0] && !scl_d) begin
      period <= cyc_n - last_rise;
      last_rise <= cyc_n;
    end
    if (!rst && oe_n[1:0] !== 2'b11) touched <= 1'b1;
  end
  // Compare read data against the oldest note
  always @(negedge clk) begin
    if (ack && chk) cmp(dat_r & mq.pop_front(), eq.pop_front());
  end
  ////////////////////////////////////////
  function automatic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task cmp(input [31:0] g, input [31:0] e);
    comparisons = comparisons + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task cmp_port(input [15:0] g, input [15:0] e);
    cmp({16'h0000, g}, {16'h0000, e});
  endtask
  // One classic cycle; a read notes its expected value and mask first
  task bus(input w, input [7:0] aa, input [7:0] d, input [7:0] m);
    begin
      if (!w) begin
        eq.push_back({24'h000000, d & m});
        mq.push_back({24'hFFFFFF, m});
      end
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= aa;
      dat_w <= {24'h000000, d};
      chk <= !w;
      @(posedge clk);
      while (!ack) @(posedge clk);
      cyc <= 1'b0;
      stb <= 1'b0;
      chk <= 1'b0;
      @(posedge clk);
    end
  endtask
  // Launch one command on unit zero, wait for its flag, check and clear it
  task run(input [1:0] c, input [1:0] res);
    reg [7:0] ctl;
    begin
      ctl = {1'b1, 1'b0, rate, c, 2'b11};
      bus(1'b1, 8'h04, ctl, 8'h00);
      bus(1'b0, 8'h04, ctl & 8'hFD, 8'hFF);
      while (!irq[0]) @(posedge clk);
      bus(1'b0, 8'h08, {5'h00, res, 1'b1}, 8'h07);
      bus(1'b1, 8'h08, 8'h01, 8'h00);
      cmp_port({14'h0000, irq}, 16'h0000);
    end
  endtask
  // Watchdog sized for the slowest rate code
  initial begin
    #9000000;
    err_total = err_total + 1;
    end_sim;
  end
  // Scenario: write, read, repeated start to an absent slave, wake on unit one
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rv = xs();
    rate = rv[1:0];
    rv = xs();
    tx = rv[7:0];
    bus(1'b1, 8'h0C, 8'hA0, 8'h00);
    bus(1'b1, 8'h10, tx, 8'h00);
    bus(1'b0, 8'h10, tx, 8'hFF);
    run(2'h0, 2'h0);
    run(2'h1, 2'h0);
    cmp_port({8'h00, got}, {8'h00, tx});
    cmp_port(period[15:0], 16'h0080 << rate);
    run(2'h3, 2'h0);
    bus(1'b0, 8'h08, 8'hC0, 8'hFF);
    bus(1'b1, 8'h0C, 8'hA1, 8'h00);
    run(2'h0, 2'h0);
    run(2'h1, 2'h0);
    cmp_port({15'h0000, sack}, 16'h0000);
    run(2'h2, 2'h0);
    cmp_port({15'h0000, sack}, 16'h0001);
    bus(1'b0, 8'h14, 8'hA5, 8'hFF);
    bus(1'b1, 8'h0C, 8'h22, 8'h00);
    run(2'h0, 2'h1);
    run(2'h3, 2'h0);
    cmp_port({15'h0000, touched}, 16'h0001);
    bus(1'b1, 8'h00, 8'h81, 8'h00);
    drag <= 1'b1;
    repeat (2) @(posedge clk);
    cmp_port({14'h0000, wake}, 16'h0002);
    bus(1'b0, 8'h08, 8'h40, 8'hC0);
    bus(1'b0, 8'h00, 8'h81, 8'hFF);
    drag <= 1'b0;
    bus(1'b0, 8'h20, 8'h00, 8'hFF);
    bus(1'b1, 8'h00, 8'h00, 8'h00);
    bus(1'b1, 8'h04, 8'h00, 8'h00);
    repeat (2) @(posedge clk);
    cmp_port({10'h000, oe_n}, 16'h003F);
    end_sim;
  end
  task end_sim;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
endmodule
